/* design/stc_arbiter.sv */
// Grants one of N FIFO requesters under fixed or revolving priority
// Assumes requests are levels on clk held until the grant is used up
`default_nettype none

module stc_arbiter
	import stc_pkg::*;
#(
	parameter int N  = 7,
	parameter int PW = 3
) (
	input  wire logic            clk,
	input  wire logic            reset,
	input  wire logic            revolving,
	input  wire logic [N*PW-1:0] prio_flat,
	input  wire logic [N-1:0]    req,
	output logic      [N-1:0]    gnt
);
	localparam int IW = $clog2(N);

	stc_arb_state_e state;
	stc_arb_state_e next_state;
	logic [IW-1:0]  owner;
	logic [IW-1:0]  next_owner;
	logic [N-1:0]   next_gnt;
	logic [N-1:0]   eligible;
	logic [IW-1:0]  fixed_idx;
	logic [IW-1:0]  rr_idx;
	logic [PW:0]    best;
	logic           found;
	int             j;

	for (genvar i = 0; i < N; i++) begin : g_elig
		assign eligible[i] = req[i] && (prio_flat[i*PW +: PW] != '0);
	end

	always_comb begin
		best = '1;
		fixed_idx = '0;
		rr_idx = '0;
		found = 1'b0;
		j = 0;
		// Lowest level number wins, lower index breaks ties
		for (int i = 0; i < N; i++) begin
			if (eligible[i] && ({1'b0, prio_flat[i*PW +: PW]} < best)) begin
				best = {1'b0, prio_flat[i*PW +: PW]};
				fixed_idx = IW'(i);
			end
		end
		// First pending requester after the last owner
		for (int k = 1; k <= N; k++) begin
			j = (int'(owner) + k) % N;
			if (!found && eligible[j]) begin
				found = 1'b1;
				rr_idx = IW'(j);
			end
		end
		next_state = state;
		next_owner = owner;
		next_gnt = gnt;
		unique case (state)
			STC_ARB_IDLE: begin
				if (|eligible) begin
					next_state = STC_ARB_OWN;
					next_owner = revolving ? rr_idx : fixed_idx;
					next_gnt = N'(1) << (revolving ? rr_idx : fixed_idx);
				end
			end
			STC_ARB_OWN: begin
				if (!eligible[owner]) begin
					next_state = STC_ARB_IDLE;
					next_gnt = '0;
				end
			end
			default: begin
				next_state = STC_ARB_IDLE;
				next_gnt = '0;
			end
		endcase
		if (reset) begin
			next_state = STC_ARB_IDLE;
			next_owner = IW'(N - 1);
			next_gnt = '0;
		end
	end

	always_ff @(posedge clk) begin
		state <= next_state;
		owner <= next_owner;
		gnt <= next_gnt;
	end
endmodule

`default_nettype wire

/* design/stc_decode.sv */
// Turns the timing control word into registered controller settings
// Assumes ctrl_word is stable logic on clk; reserved codes decode to zero
`default_nettype none

module stc_decode
	import stc_pkg::*;
(
	input  wire logic   clk,
	input  wire logic   reset,
	stc_timing_if.decode tif
);
	stc_timing_s next_t;
	stc_timing_s t;
	logic [31:0] w;

	always_comb begin
		w = tif.ctrl_word;
		next_t = '0;
		unique case (w[`STC_SYS_BURST_LSB +: 3])
			3'h0: next_t.sys_burst_words = 4'h1;
			3'h1: next_t.sys_burst_words = 4'h2;
			3'h2: next_t.sys_burst_words = 4'h4;
			3'h3: next_t.sys_burst_words = 4'h8;
			default: next_t.sys_burst_words = 4'h0;
		endcase
		next_t.sys_cas_clocks = w[`STC_SYS_CAS_BIT] ? `STC_CAS_LONG : `STC_CAS_SHORT;
		unique case (w[`STC_SYS_SIZE_LSB +: 3])
			3'h0: next_t.sys_size_mb = 7'h02;
			3'h1: next_t.sys_size_mb = 7'h04;
			3'h4: next_t.sys_size_mb = 7'h40;
			3'h5: next_t.sys_size_mb = 7'h20;
			3'h6: next_t.sys_size_mb = 7'h10;
			3'h7: next_t.sys_size_mb = 7'h08;
			default: next_t.sys_size_mb = 7'h00;
		endcase
		unique case (w[`STC_SYS_COL_LSB +: 2])
			2'h0: next_t.sys_columns = 11'h400;
			2'h2: next_t.sys_columns = 11'h200;
			2'h3: next_t.sys_columns = 11'h100;
			default: next_t.sys_columns = 11'h000;
		endcase
		next_t.sys_act_pchg_clocks = stc_act_pchg(w[`STC_SYS_ACT_PCHG_BIT]);
		next_t.sys_bank_count = stc_banks(w[`STC_SYS_BANKS_BIT]);
		next_t.sys_wr_pchg_clocks = stc_wr_pchg(w[`STC_SYS_WR_PCHG_BIT]);
		next_t.local_blockwrite_enable = w[`STC_LOC_BW_EN_BIT];
		next_t.local_bw_cycle_clocks = w[`STC_LOC_BW_CYC_BIT] ?
			`STC_BW_CYC_LONG : `STC_BW_CYC_SHORT;
		next_t.local_bw_pchg_clocks = w[`STC_LOC_BW_PCHG_BIT] ?
			`STC_BW_PCHG_FAST : `STC_BW_PCHG_SLOW;
		next_t.local_refresh_wait_clocks = w[`STC_LOC_RFSH_BIT] ?
			`STC_RFSH_LONG : `STC_RFSH_SHORT;
		unique case (w[`STC_LOC_SIZE_LSB +: 3])
			3'h0: next_t.local_size_mb = 7'h04;
			3'h1: next_t.local_size_mb = 7'h08;
			3'h2: next_t.local_size_mb = 7'h10;
			3'h3: next_t.local_size_mb = 7'h20;
			3'h4: next_t.local_size_mb = 7'h40;
			3'h5: next_t.local_size_mb = 7'h02;
			default: next_t.local_size_mb = 7'h00;
		endcase
		unique case (w[`STC_LOC_COL_LSB +: 2])
			2'h0: next_t.local_columns = 11'h100;
			2'h2: next_t.local_columns = 11'h200;
			2'h3: next_t.local_columns = 11'h400;
			default: next_t.local_columns = 11'h000;
		endcase
		next_t.local_act_pchg_clocks = stc_act_pchg(w[`STC_LOC_ACT_PCHG_BIT]);
		next_t.local_keep_row_open = ~w[`STC_LOC_ROW_OPEN_BIT];
		next_t.local_bank_count = stc_banks(w[`STC_LOC_BANKS_BIT]);
		next_t.local_wr_pchg_clocks = stc_wr_pchg(w[`STC_LOC_WR_PCHG_BIT]);
		if (reset) begin
			next_t = '0;
		end
	end

	always_ff @(posedge clk) begin
		t <= next_t;
	end

	assign tif.timing = t;
endmodule

`default_nettype wire

/* design/stc_pkg.sv */
// Types and field decoders shared by the configuration block
// Assumes stc_regs.svh on the include path
`default_nettype none

package stc_pkg;
	`include "stc_regs.svh"

	typedef struct packed {
		logic [3:0]  sys_burst_words;
		logic [1:0]  sys_cas_clocks;
		logic [6:0]  sys_size_mb;
		logic [10:0] sys_columns;
		logic [2:0]  sys_act_pchg_clocks;
		logic [2:0]  sys_bank_count;
		logic [1:0]  sys_wr_pchg_clocks;
		logic        local_blockwrite_enable;
		logic [1:0]  local_bw_cycle_clocks;
		logic [2:0]  local_bw_pchg_clocks;
		logic [3:0]  local_refresh_wait_clocks;
		logic [6:0]  local_size_mb;
		logic [10:0] local_columns;
		logic [2:0]  local_act_pchg_clocks;
		logic        local_keep_row_open;
		logic [2:0]  local_bank_count;
		logic [1:0]  local_wr_pchg_clocks;
	} stc_timing_s;

	typedef enum logic [1:0] {
		STC_ARB_IDLE = 2'b01,
		STC_ARB_OWN  = 2'b10
	} stc_arb_state_e;

	function automatic logic [2:0] stc_act_pchg(input logic sel);
		return sel ? `STC_ACT_PCHG_LONG : `STC_ACT_PCHG_SHORT;
	endfunction

	function automatic logic [2:0] stc_banks(input logic sel);
		return sel ? `STC_BANKS_TWO : `STC_BANKS_FOUR;
	endfunction

	function automatic logic [1:0] stc_wr_pchg(input logic sel);
		return sel ? `STC_WR_PCHG_FAST : `STC_WR_PCHG_SLOW;
	endfunction
endpackage

`default_nettype wire

/* design/stc_regs.svh */
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the package only
`ifndef STC_REGS_SVH
`define STC_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define STC_OFF_TIMING        16'h0010
`define STC_OFF_ARB           16'h0014

// ****************************************
// Timing control fields
// ****************************************
`define STC_EMB_DISABLE_BIT   31
`define STC_SYS_BURST_LSB     28
`define STC_SYS_CAS_BIT       27
`define STC_SYS_SIZE_LSB      24
`define STC_SYS_COL_LSB       22
`define STC_SYS_ACT_PCHG_BIT  21
`define STC_SYS_RUN_BIT       20
`define STC_SYS_BANKS_BIT     19
`define STC_SYS_WR_PCHG_BIT   18
`define STC_LOC_BW_EN_BIT     17
`define STC_LOC_RFSH_BIT      16
`define STC_LOC_SIZE_LSB      13
`define STC_LOC_COL_LSB       11
`define STC_LOC_BW_CYC_BIT    10
`define STC_LOC_BW_PCHG_BIT   9
`define STC_LOC_ACT_PCHG_BIT  8
`define STC_LOC_RUN_BIT       7
`define STC_LOC_ROW_OPEN_BIT  6
`define STC_LOC_BANKS_BIT     1
`define STC_LOC_WR_PCHG_BIT   0
`define STC_TIMING_RESET      32'h07F107C0
`define STC_TIMING_WMASK      32'h7FFFFFC3

// ****************************************
// Arbitration control fields
// ****************************************
`define STC_ARB_SYS_REV_BIT   29
`define STC_ARB_INT_REV_BIT   28
`define STC_ARB_FIELD_STRIDE  4
`define STC_ARB_RESET         32'h05146732
`define STC_ARB_WMASK         32'h37777777

// ****************************************
// Timing counts in memory clocks, and bank counts
// ****************************************
`define STC_CAS_SHORT         2'h2
`define STC_CAS_LONG          2'h3
`define STC_ACT_PCHG_SHORT    3'h6
`define STC_ACT_PCHG_LONG     3'h7
`define STC_WR_PCHG_SLOW      2'h2
`define STC_WR_PCHG_FAST      2'h1
`define STC_BW_CYC_SHORT      2'h1
`define STC_BW_CYC_LONG       2'h2
`define STC_BW_PCHG_SLOW      3'h4
`define STC_BW_PCHG_FAST      3'h1
`define STC_RFSH_SHORT        4'hA
`define STC_RFSH_LONG         4'hC
`define STC_BANKS_FOUR        3'h4
`define STC_BANKS_TWO         3'h2

`endif

/* design/stc_sdram_cfg.sv */
// Memory timing and arbitration configuration for both SDRAM controllers
// Assumes host register port and strap pins; straps are asynchronous
`default_nettype none

module stc_sdram_cfg
	import stc_pkg::*;
#(
	parameter int NREQ   = 7,
	parameter int ADDR_W = 16
) (
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              embedded_strap_pin,
	input  wire logic [2:0]        local_size_strap,
	input  wire logic [1:0]        local_column_strap,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [31:0]       reg_wdata,
	output logic      [31:0]       reg_rdata,
	output logic                   reg_rvalid,
	input  wire logic [NREQ-1:0]   sys_req,
	output logic      [NREQ-1:0]   sys_gnt,
	input  wire logic [NREQ-1:0]   int_req,
	output logic      [NREQ-1:0]   int_gnt,
	output logic                   embedded_mem_disable,
	output logic                   sys_ctrl_reset,
	output logic                   local_ctrl_reset,
	output logic      [3:0]        sys_burst_words,
	output logic      [1:0]        sys_cas_clocks,
	output logic      [6:0]        sys_size_mb,
	output logic      [10:0]       sys_columns,
	output logic      [2:0]        sys_act_pchg_clocks,
	output logic      [2:0]        sys_bank_count,
	output logic      [1:0]        sys_wr_pchg_clocks,
	output logic                   local_blockwrite_enable,
	output logic      [1:0]        local_bw_cycle_clocks,
	output logic      [2:0]        local_bw_pchg_clocks,
	output logic      [3:0]        local_refresh_wait_clocks,
	output logic      [6:0]        local_size_mb,
	output logic      [10:0]       local_columns,
	output logic      [2:0]        local_act_pchg_clocks,
	output logic                   local_keep_row_open,
	output logic      [2:0]        local_bank_count,
	output logic      [1:0]        local_wr_pchg_clocks
);
	localparam int PW = 3;

	// ****************************************
	// Strap synchronisers
	// ****************************************
	logic [5:0] strap_meta;
	logic [5:0] strap_sync;

	always_ff @(posedge clk) begin
		strap_meta <= {embedded_strap_pin, local_size_strap, local_column_strap};
		strap_sync <= strap_meta;
	end

	// ****************************************
	// Register file
	// ****************************************
	logic [31:0] timing_ctrl;
	logic [31:0] next_timing_ctrl;
	logic [31:0] arb_ctrl;
	logic [31:0] next_arb_ctrl;
	logic [31:0] next_rdata;
	logic        next_rvalid;
	logic [31:0] strap_word;
	logic        hit_timing;
	logic        hit_arb;

	assign hit_timing = (reg_addr == ADDR_W'(`STC_OFF_TIMING));
	assign hit_arb    = (reg_addr == ADDR_W'(`STC_OFF_ARB));

	always_comb begin
		strap_word = `STC_TIMING_RESET;
		strap_word[`STC_EMB_DISABLE_BIT] = strap_sync[5];
		strap_word[`STC_LOC_SIZE_LSB +: 3] = strap_sync[4:2];
		strap_word[`STC_LOC_COL_LSB +: 2] = strap_sync[1:0];
		next_timing_ctrl = timing_ctrl;
		next_arb_ctrl = arb_ctrl;
		next_rdata = reg_rdata;
		next_rvalid = 1'b0;
		if (reg_wr && hit_timing) begin
			// Bit 31 and reserved bits keep their value
			next_timing_ctrl = (reg_wdata & `STC_TIMING_WMASK) |
				(timing_ctrl & ~`STC_TIMING_WMASK);
		end
		if (reg_wr && hit_arb) begin
			next_arb_ctrl = reg_wdata & `STC_ARB_WMASK;
		end
		if (reg_rd) begin
			next_rvalid = 1'b1;
			if (hit_timing) begin
				next_rdata = timing_ctrl;
			end else if (hit_arb) begin
				next_rdata = arb_ctrl;
			end else begin
				next_rdata = '0;
			end
		end
		if (reset) begin
			next_timing_ctrl = strap_word;
			next_arb_ctrl = `STC_ARB_RESET;
			next_rdata = '0;
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		timing_ctrl <= next_timing_ctrl;
		arb_ctrl <= next_arb_ctrl;
		reg_rdata <= next_rdata;
		reg_rvalid <= next_rvalid;
	end

	// ****************************************
	// Controller resets and strap status
	// ****************************************
	logic next_sys_ctrl_reset;
	logic next_local_ctrl_reset;
	logic next_embedded_mem_disable;

	always_comb begin
		next_sys_ctrl_reset = reset | ~timing_ctrl[`STC_SYS_RUN_BIT];
		next_local_ctrl_reset = reset | ~timing_ctrl[`STC_LOC_RUN_BIT];
		next_embedded_mem_disable = timing_ctrl[`STC_EMB_DISABLE_BIT];
		if (reset) begin
			next_sys_ctrl_reset = 1'b1;
			next_local_ctrl_reset = 1'b1;
			next_embedded_mem_disable = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		sys_ctrl_reset <= next_sys_ctrl_reset;
		local_ctrl_reset <= next_local_ctrl_reset;
		embedded_mem_disable <= next_embedded_mem_disable;
	end

	// ****************************************
	// Field decoder
	// ****************************************
	stc_timing_if tif ();

	assign tif.ctrl_word = timing_ctrl;

	stc_decode u_decode (
		.clk   (clk),
		.reset (reset),
		.tif   (tif)
	);

	assign sys_burst_words           = tif.timing.sys_burst_words;
	assign sys_cas_clocks            = tif.timing.sys_cas_clocks;
	assign sys_size_mb               = tif.timing.sys_size_mb;
	assign sys_columns               = tif.timing.sys_columns;
	assign sys_act_pchg_clocks       = tif.timing.sys_act_pchg_clocks;
	assign sys_bank_count            = tif.timing.sys_bank_count;
	assign sys_wr_pchg_clocks        = tif.timing.sys_wr_pchg_clocks;
	assign local_blockwrite_enable   = tif.timing.local_blockwrite_enable;
	assign local_bw_cycle_clocks     = tif.timing.local_bw_cycle_clocks;
	assign local_bw_pchg_clocks      = tif.timing.local_bw_pchg_clocks;
	assign local_refresh_wait_clocks = tif.timing.local_refresh_wait_clocks;
	assign local_size_mb             = tif.timing.local_size_mb;
	assign local_columns             = tif.timing.local_columns;
	assign local_act_pchg_clocks     = tif.timing.local_act_pchg_clocks;
	assign local_keep_row_open       = tif.timing.local_keep_row_open;
	assign local_bank_count          = tif.timing.local_bank_count;
	assign local_wr_pchg_clocks      = tif.timing.local_wr_pchg_clocks;

	// ****************************************
	// Requester priorities and arbiters
	// ****************************************
	logic [NREQ*PW-1:0] prio_flat;

	// Index 0 CRT, 1 video, 2 DMA, 3 command list, 4 capture, 5 panel, 6 USB
	for (genvar i = 0; i < NREQ; i++) begin : g_prio
		assign prio_flat[i*PW +: PW] = arb_ctrl[i*`STC_ARB_FIELD_STRIDE +: PW];
	end

	stc_arbiter #(
		.N  (NREQ),
		.PW (PW)
	) u_sys_arb (
		.clk       (clk),
		.reset     (reset),
		.revolving (arb_ctrl[`STC_ARB_SYS_REV_BIT]),
		.prio_flat (prio_flat),
		.req       (sys_req),
		.gnt       (sys_gnt)
	);

	stc_arbiter #(
		.N  (NREQ),
		.PW (PW)
	) u_int_arb (
		.clk       (clk),
		.reset     (reset),
		.revolving (arb_ctrl[`STC_ARB_INT_REV_BIT]),
		.prio_flat (prio_flat),
		.req       (int_req),
		.gnt       (int_gnt)
	);
endmodule

`default_nettype wire

/* design/stc_timing_if.sv */
// Carrier between the register file and the field decoder
// Assumes one clock domain shared by both ends
`default_nettype none

interface stc_timing_if;
	import stc_pkg::*;
	logic [31:0] ctrl_word;
	stc_timing_s timing;

	modport regs (output ctrl_word, input timing);
	modport decode (input ctrl_word, output timing);
endinterface

`default_nettype wire

/* test/stc_req_model.sv */
// Requester model: seven system and seven internal FIFO requesters
// Assumes kick pulses from the bench; each request is held until served
`default_nettype none

module stc_req_model #(
	parameter int	HOLD_S = 2,
	parameter int	HOLD_I = 5
) (
	input	wire logic		clk,
	input	wire logic		reset,
	input	wire logic [13:0]	kick,
	input	wire logic [13:0]	gnt,
	output	logic [13:0]		req
);
	int	cnt [14];

	// Slow internal side, prompt system side
	always_ff @(posedge clk) begin
		for (int i = 0; i < 14; i++) begin
			if (reset) begin
				req[i] <= 1'h0;
				cnt[i] <= 0;
			end else if (kick[i]) begin
				req[i] <= 1'h1;
			end else if (req[i] && gnt[i]) begin
				cnt[i] <= cnt[i] + 1;
				if (cnt[i] == (i < 7 ? HOLD_S : HOLD_I) - 1) begin
					req[i] <= 1'h0;
					cnt[i] <= 0;
				end
			end
		end
	end
endmodule

`default_nettype wire

/* test/stc_sdram_cfg_sva.sv */
// Port checker for the memory configuration block
// Assumes one clock domain with synchronous active-high reset
`default_nettype none

module stc_sdram_cfg_sva #(
	parameter int	NREQ = 7,
	parameter int	ADDR_W = 16
) (
	input	wire logic			clk,
	input	wire logic			reset,
	input	wire logic [ADDR_W-1:0]		reg_addr,
	input	wire logic			reg_wr,
	input	wire logic			reg_rd,
	input	wire logic [31:0]		reg_wdata,
	input	wire logic [31:0]		reg_rdata,
	input	wire logic			reg_rvalid,
	input	wire logic [NREQ-1:0]		sys_req,
	input	wire logic [NREQ-1:0]		sys_gnt,
	input	wire logic [NREQ-1:0]		int_req,
	input	wire logic [NREQ-1:0]		int_gnt,
	input	wire logic			embedded_mem_disable,
	input	wire logic			sys_ctrl_reset,
	input	wire logic			local_ctrl_reset,
	input	wire logic [1:0]		sys_cas_clocks,
	input	wire logic [3:0]		local_refresh_wait_clocks
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	rd_answer_a: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered");
	rvalid_pulse_a: assert property (!reg_rd |=> !reg_rvalid)
		else $error("read valid without read");
	unmapped_zero_a: assert property (reg_rd && reg_addr != 16'h0010 && reg_addr != 16'h0014
		|=> reg_rdata == 32'h0) else $error("unmapped read not zero");
	gnt_onehot_a: assert property ($onehot0(sys_gnt) && $onehot0(int_gnt))
		else $error("grant not one-hot");
	gnt_cause_a: assert property (((sys_gnt & ~$past(sys_req)) | (int_gnt & ~$past(int_req))) == '0)
		else $error("grant without request");
	gnt_hold_a: assert property (|sys_gnt && |$past(sys_gnt) |-> sys_gnt == $past(sys_gnt))
		else $error("grant switched without idle");
	gnt_drop_a: assert property (|(int_gnt & ~int_req) |=> int_gnt == '0)
		else $error("grant kept after request ended");
	sys_run_a: assert property (reg_wr && reg_addr == 16'h0010 && !reg_wdata[20]
		|-> ##2 sys_ctrl_reset) else $error("system controller not held in reset");
	local_run_a: assert property (reg_wr && reg_addr == 16'h0010 && reg_wdata[7]
		|-> ##2 !local_ctrl_reset) else $error("local controller not released");
	cas_long_a: assert property (reg_wr && reg_addr == 16'h0010 && reg_wdata[27]
		|-> ##2 sys_cas_clocks == 2'h3) else $error("cas latency not three");
	rfsh_short_a: assert property (reg_wr && reg_addr == 16'h0010 && !reg_wdata[16]
		|-> ##2 local_refresh_wait_clocks == 4'hA) else $error("refresh wait not ten");
	strap_hold_a: assert property (!$past(reset, 1) && !$past(reset, 2)
		|-> $stable(embedded_mem_disable)) else $error("embedded disable changed");
	reset_state_a: assert property (disable iff (1'h0) reset |=> sys_ctrl_reset &&
		local_ctrl_reset && sys_gnt == '0 && int_gnt == '0) else $error("bad reset state");

	cover property (reg_rvalid);
	cover property (|sys_gnt ##1 !(|sys_gnt) ##1 |sys_gnt);
	cover property (|int_gnt ##1 !(|int_gnt) ##1 |int_gnt);
endmodule

bind stc_sdram_cfg stc_sdram_cfg_sva #(.NREQ(NREQ), .ADDR_W(ADDR_W)) stc_sdram_cfg_sva_i (
	.clk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
	.sys_req, .sys_gnt, .int_req, .int_gnt, .embedded_mem_disable, .sys_ctrl_reset,
	.local_ctrl_reset, .sys_cas_clocks, .local_refresh_wait_clocks);

`default_nettype wire

/* test/stc_sdram_cfg_tb_top.sv */
// Self-checking bench for the memory timing and arbitration block
// Assumes the requester model and the port checker are compiled first
`default_nettype none

module stc_sdram_cfg_tb_top
	import stc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic		strap_emb;
	logic [2:0]	strap_size;
	logic [1:0]	strap_col;

	logic		clk;
	logic		reset;
	logic [15:0]	reg_addr;
	logic		reg_wr;
	logic		reg_rd;
	logic [31:0]	reg_wdata;
	logic [31:0]	reg_rdata;
	logic		reg_rvalid;
	logic [13:0]	kick;
	wire logic [6:0]	sys_req;
	wire logic [6:0]	int_req;
	logic [6:0]	sys_gnt;
	logic [6:0]	int_gnt;
	logic [6:0]	sys_gnt_d;
	logic [6:0]	int_gnt_d;
	logic		embedded_mem_disable;
	logic		sys_ctrl_reset;
	logic		local_ctrl_reset;
	wire stc_timing_s	dec;
	int		fail_count;
	int		check_count;
	int		sys_order[$];
	int		int_order[$];

	stc_sdram_cfg stc_sdram_cfg_i (
		.clk, .reset, .embedded_strap_pin(strap_emb), .local_size_strap(strap_size),
		.local_column_strap(strap_col), .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
		.reg_rdata, .reg_rvalid, .sys_req, .sys_gnt, .int_req, .int_gnt,
		.embedded_mem_disable, .sys_ctrl_reset, .local_ctrl_reset,
		.sys_burst_words(dec.sys_burst_words), .sys_cas_clocks(dec.sys_cas_clocks),
		.sys_size_mb(dec.sys_size_mb), .sys_columns(dec.sys_columns),
		.sys_act_pchg_clocks(dec.sys_act_pchg_clocks), .sys_bank_count(dec.sys_bank_count),
		.sys_wr_pchg_clocks(dec.sys_wr_pchg_clocks),
		.local_blockwrite_enable(dec.local_blockwrite_enable),
		.local_bw_cycle_clocks(dec.local_bw_cycle_clocks),
		.local_bw_pchg_clocks(dec.local_bw_pchg_clocks),
		.local_refresh_wait_clocks(dec.local_refresh_wait_clocks),
		.local_size_mb(dec.local_size_mb), .local_columns(dec.local_columns),
		.local_act_pchg_clocks(dec.local_act_pchg_clocks),
		.local_keep_row_open(dec.local_keep_row_open), .local_bank_count(dec.local_bank_count),
		.local_wr_pchg_clocks(dec.local_wr_pchg_clocks));

	stc_req_model stc_req_model_i (.clk, .reset, .kick, .gnt({int_gnt, sys_gnt}),
		.req({int_req, sys_req}));

	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end

	// Order in which grants start
	always @(posedge clk) begin
		sys_gnt_d <= sys_gnt;
		int_gnt_d <= int_gnt;
		for (int i = 0; i < 7; i++) begin
			if (sys_gnt[i] && !sys_gnt_d[i]) sys_order.push_back(i);
			if (int_gnt[i] && !int_gnt_d[i]) int_order.push_back(i);
		end
	end

	// ****************************************
	// Helpers
	// ****************************************
	task automatic wrap_up();
		if (fail_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_dec(input stc_timing_s got, input stc_timing_s exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: settings %h expected %h", $time, got, exp);
		end
	endtask

	task automatic step();
		@(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		step();
		reg_wr <= 1'h0;
	endtask

	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'h1;
		step();
		reg_rd <= 1'h0;
		chk_word({31'h0, reg_rvalid}, 32'h1);
		d = reg_rdata;
		step();
	endtask

	function automatic stc_timing_s exp_dec(input logic [31:0] w);
		stc_timing_s e;
		logic [6:0] ssz[8] = '{7'h02, 7'h04, 7'h00, 7'h00, 7'h40, 7'h20, 7'h10, 7'h08};
		logic [6:0] lsz[8] = '{7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h02, 7'h00, 7'h00};
		logic [10:0] scol[4] = '{11'h400, 11'h000, 11'h200, 11'h100};
		logic [10:0] lcol[4] = '{11'h100, 11'h000, 11'h200, 11'h400};
		e.sys_burst_words = w[30] ? 4'h0 : 4'h1 << w[29:28];
		e.sys_cas_clocks = w[27] ? 2'h3 : 2'h2;
		e.sys_size_mb = ssz[w[26:24]];
		e.sys_columns = scol[w[23:22]];
		e.sys_act_pchg_clocks = w[21] ? 3'h7 : 3'h6;
		e.sys_bank_count = w[19] ? 3'h2 : 3'h4;
		e.sys_wr_pchg_clocks = w[18] ? 2'h1 : 2'h2;
		e.local_blockwrite_enable = w[17];
		e.local_bw_cycle_clocks = w[10] ? 2'h2 : 2'h1;
		e.local_bw_pchg_clocks = w[9] ? 3'h1 : 3'h4;
		e.local_refresh_wait_clocks = w[16] ? 4'hC : 4'hA;
		e.local_size_mb = lsz[w[15:13]];
		e.local_columns = lcol[w[12:11]];
		e.local_act_pchg_clocks = w[8] ? 3'h7 : 3'h6;
		e.local_keep_row_open = !w[6];
		e.local_bank_count = w[1] ? 3'h2 : 3'h4;
		e.local_wr_pchg_clocks = w[0] ? 2'h1 : 2'h2;
		return e;
	endfunction

	task automatic order_check(input int q[$], input logic rev, input int first);
		int fixed_order[6] = '{2, 6, 5, 4, 3, 1};
		int e;
		chk_word(32'(q.size()), 32'h6);
		foreach (q[k]) begin
			if (!rev) e = fixed_order[k % 6];
			else if (k == 0) e = first;
			else e = q[k-1] % 6 + 1;
			chk_word(32'(q[k]), 32'(e));
		end
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset(input logic e, input logic [2:0] s, input logic [1:0] c);
		logic [31:0] d;
		logic [31:0] por;
		por = 32'h07F107C0 | {e, 15'h0, s, c, 11'h0};
		strap_emb <= e;
		strap_size <= s;
		strap_col <= c;
		reset <= 1'h1;
		repeat (3) step();
		reset <= 1'h0;
		repeat (2) step();
		rd(16'h0010, d);
		chk_word(d, por);
		rd(16'h0014, d);
		chk_word(d, 32'h05146732);
		chk_dec(dec, exp_dec(por));
		chk_word({29'h0, embedded_mem_disable, sys_ctrl_reset, local_ctrl_reset},
			{29'h0, e, 2'h0});
	endtask

	task automatic t_regs();
		logic [31:0] d;
		wr(16'h0014, 32'hFFFFFFFF);
		rd(16'h0014, d);
		chk_word(d, 32'h37777777);
		wr(16'h0018, 32'hFFFFFFFF);
		rd(16'h0018, d);
		chk_word(d, 32'h00000000);
		rd(16'h0014, d);
		chk_word(d, 32'h37777777);
	endtask

	task automatic t_decode();
		logic [31:0] words[7] = '{32'h00000000, 32'h11803000, 32'h24404800, 32'h35106080,
			32'h06008000, 32'h40000000, 32'h7FFFFFFF};
		logic [31:0] d;
		foreach (words[k]) begin
			wr(16'h0010, words[k]);
			rd(16'h0010, d);
			chk_word(d, (words[k] & 32'h7FFFFFC3) | 32'h80000000);
			repeat (2) step();
			chk_dec(dec, exp_dec(words[k]));
			chk_word({sys_ctrl_reset, local_ctrl_reset}, {!words[k][20], !words[k][7]});
		end
	endtask

	task automatic t_arb(input logic [31:0] w, input int first);
		int n;
		sys_order.delete();
		int_order.delete();
		wr(16'h0014, w);
		kick <= 14'h3FFF;
		step();
		kick <= 14'h0000;
		n = 0;
		while ((sys_req[6:1] | int_req[6:1]) != 6'h00 && n < 400) begin
			step();
			n++;
		end
		if (n == 400) begin
			fail_count++;
			$display("mismatch at %0t: requests never served", $time);
			wrap_up();
		end
		repeat (2) step();
		order_check(sys_order, w[29], first);
		order_check(int_order, w[28], first);
	endtask

	initial begin
		reset = 1'h1;
		reg_addr = 16'h0000;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_wdata = 32'h00000000;
		kick = 14'h0000;
		t_reset(1'h1, 3'h5, 2'h3);
		t_regs();
		t_decode();
		t_arb(32'h11234160, 1);
		t_arb(32'h21234160, 2);
		t_reset(1'h0, 3'h2, 2'h2);
		wrap_up();
	end
endmodule

`default_nettype wire
